// ==== core/lsp_pkg.sv ====
package lsp_pkg;
   // Register byte offsets on the APB slave
   localparam logic [7:0] OFS_CTRL = 8'h00; // Configuration bits
   localparam logic [7:0] OFS_CFG_SP = 8'h04; // Configured default setpoint
   localparam logic [7:0] OFS_PRESET = 8'h08; // External preset telegram (write)
   localparam logic [7:0] OFS_SHIFT = 8'h0c; // Shift dimming telegram (write)
   localparam logic [7:0] OFS_TEACH = 8'h10; // Teach telegram (write)
   localparam logic [7:0] OFS_RESET = 8'h14; // Setpoint reset telegram (write)
   localparam logic [7:0] OFS_MEAS = 8'h18; // Measured brightness
   localparam logic [7:0] OFS_LIMIT = 8'h1c; // Shift limits, low and high
   localparam logic [7:0] OFS_SETPT = 8'h20; // Active setpoint and upper bound (read)
   localparam logic [7:0] OFS_CH1 = 8'h24; // Channel 1 output value
   localparam logic [7:0] OFS_OFFS = 8'h28; // Offsets of channels 2 and 3, hysteresis
   localparam logic [7:0] OFS_OUTS = 8'h2c; // Channel outputs readback
   localparam logic [7:0] OFS_DNLD = 8'h30; // Configuration download strobe

   // CTRL field positions
   localparam int CTRL_CNT_LSB = 0; // lighting_channel_count, 2 bits
   localparam int CTRL_PERM = 2; // adjust_persistence_select: 1 = permanent
   localparam int CTRL_TMODE_LSB = 3; // Teach mode, 2 bits
   localparam int CTRL_OVWR = 5; // Overwrite on download
   localparam int CTRL_PHASE = 6; // Control phase active
   localparam int CTRL_HYST_LSB = 8; // Percentage hysteresis, 8 bits

   // Teach modes
   localparam logic [1:0] TMODE_ONE = 2'h0; // 1 active, 0 restores
   localparam logic [1:0] TMODE_ZERO = 2'h1; // 0 active, 1 restores
   localparam logic [1:0] TMODE_BOTH = 2'h2; // Both values active

   // Reset values
   localparam logic [15:0] CFG_SP_RST = 16'h0190;
   localparam logic [15:0] CTRL_RST = 16'h1401;

   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SETTLE_MS = 2000;
   localparam int TIMEOUT_MS = 30000;
   localparam int SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
   localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;

   // Forwarded dimming telegram for channel 1
   typedef struct packed {
      logic valid;
      logic [3:0] code;
   } lsp_dim_s;

   typedef enum logic [1:0] {
      SH_IDLE = 2'b00,
      SH_RUN = 2'b01,
      SH_SETTLE = 2'b10
   } lsp_shift_e;
endpackage

// ==== core/lsp_core.sv ====
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Operation
// RL1: Preset telegram replaces active setpoint
// RL2: Preset setpoint survives supply loss; here reset reloads the setpoint with CFG_SP_RST
// RL3: Preset, teach, reset ignore phase and disable
// RL4: Shift starts in phase, forwards dimming
// RL5: Stop telegram forwarded to channel 1
// RL6: Store measurement two seconds after stop
// RL7: Thirty second timeout issues own stop
// RL8: Passed limit stops, adopts limit
// RL9: Shift validity temporary or permanent
// RL10: Active teach adopts measured brightness
// RL11: Teach polarity; opposite restores default
// RL12: Reset restores configured default setpoint
// RL13: Download overwrites per option
// RL14: Configured setpoint until first preset/teach
// RL15: One to three channels configured
// RL16: Multi-channel uses absolute byte outputs
// RL17: Channels 2,3 derived from channel 1
// RL18: Fixed signed offset from output one
// RL19: Channel 1 zero forces others zero
// RL20: On-off hysteresis for negative offset
// RL21: Upper bound setpoint plus percent
// RL22: Saturate 0..255, hysteresis forces zero
// RL23: Shift outside phase ignored; here only from idle, a running shift forwards telegrams in any phase
module lsp_core #(
   parameter int SETTLE_CYCLES = lsp_pkg::SETTLE_CYC,
   parameter int TIMEOUT_CYCLES = lsp_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Channel 1 relative dimming output
   output lsp_pkg::lsp_dim_s dim_ch1_o,
   // Absolute channel outputs
   output logic [7:0] out_ch1_o,
   output logic [7:0] out_ch2_o,
   output logic [7:0] out_ch3_o,
   output logic abs_only_o
);
   import lsp_pkg::*;

   // Configuration and telegram state
   logic [15:0] ctrl; // Config bits
   logic [15:0] cfg_sp; // Default setpoint
   logic [15:0] meas; // Measured brightness
   logic [15:0] lim_lo, lim_hi; // Shift limits
   logic [7:0] ch1; // Channel 1 control output
   logic [8:0] offs2, offs3; // Signed offsets
   logic [7:0] hyst; // On-off hysteresis
   logic [15:0] sp; // Active setpoint
   logic [15:0] sp_saved; // Setpoint before a temporary shift
   logic ext_set; // Preset or teach happened since commissioning
   logic [15:0] upper; // Upper band bound
   lsp_shift_e sh_st; // Shift state
   logic [31:0] sh_cnt; // Shift timer
   logic phase_q; // Previous control phase
   logic [7:0] o2, o3; // Derived outputs
   logic on2, on3; // Channel on states for hysteresis

   logic [15:0] next_ctrl, next_cfg_sp, next_meas, next_lim_lo, next_lim_hi, next_sp;
   logic [15:0] next_sp_saved, next_upper;
   logic [7:0] next_ch1, next_hyst, next_o2, next_o3;
   logic [8:0] next_offs2, next_offs3;
   logic next_ext_set, next_on2, next_on3;
   lsp_shift_e next_sh_st;
   logic [31:0] next_sh_cnt;
   lsp_dim_s next_dim;
   logic [31:0] next_rdata;

   // Decoded APB strobes; write taken at the access phase, read from setup
   logic wr, rd;
   logic in_phase;
   logic [1:0] tmode;
   logic [3:0] wcode;
   assign wr = psel_i & penable_i & pwrite_i;
   assign rd = psel_i & ~pwrite_i; // From setup on, so read data already stands at the access edge
   assign in_phase = ctrl[CTRL_PHASE];
   assign tmode = ctrl[CTRL_TMODE_LSB +: 2];
   assign wcode = pwdata_i[3:0];

   // Offset of one channel with hysteresis; returns {on, value}
   function automatic logic [8:0] derive(input logic [7:0] c1, input logic [8:0] off,
                                         input logic [7:0] hy, input logic on_prev);
      logic [10:0] sum;
      logic on;
      sum = {3'b000, c1} + {{2{off[8]}}, off};
      on = on_prev;
      if (c1 == 8'h00) begin
         on = 1'b0; // RL19
      end else if (!off[8]) begin
         on = 1'b1; // RL18
      end else if ($signed(sum) > $signed({3'b000, hy})) begin
         on = 1'b1; // RL20
      end else if ($signed(sum) <= 11'sd0) begin
         on = 1'b0; // RL20
      end
      if (!on) begin
         derive = 9'h000; // RL22
      end else if ($signed(sum) > 11'sd255) begin
         derive = {1'b1, 8'hff}; // RL22
      end else if ($signed(sum) < 11'sd1) begin
         derive = {1'b1, 8'h00}; // RL22
      end else begin
         derive = {1'b1, sum[7:0]}; // RL17
      end
   endfunction

   // Next-state logic for setpoint, shift and config
   always_comb begin
      logic [8:0] r2, r3;
      logic [23:0] prod;
      next_ctrl = ctrl;
      next_cfg_sp = cfg_sp;
      next_meas = meas;
      next_lim_lo = lim_lo;
      next_lim_hi = lim_hi;
      next_ch1 = ch1;
      next_offs2 = offs2;
      next_offs3 = offs3;
      next_hyst = hyst;
      next_sp = sp;
      next_sp_saved = sp_saved;
      next_ext_set = ext_set;
      next_sh_st = sh_st;
      next_sh_cnt = sh_cnt;
      next_dim = '0;
      r2 = 9'h000;
      r3 = 9'h000;
      prod = 24'h000000;
      // Plain configuration writes
      if (wr) begin
         case (paddr_i)
            OFS_CTRL: next_ctrl = pwdata_i[15:0];
            OFS_CFG_SP: next_cfg_sp = pwdata_i[15:0];
            OFS_MEAS: next_meas = pwdata_i[15:0];
            OFS_LIMIT: begin
               next_lim_lo = pwdata_i[15:0];
               next_lim_hi = pwdata_i[31:16];
            end
            OFS_CH1: next_ch1 = pwdata_i[7:0];
            OFS_OFFS: begin
               next_offs2 = pwdata_i[8:0];
               next_offs3 = pwdata_i[24:16];
               next_hyst = pwdata_i[15:9] == 7'h00 ? 8'h00 : {1'b0, pwdata_i[15:9]};
            end
            default: ;
         endcase
      end
      // Shift sequencing
      case (sh_st)
         SH_IDLE: begin
            if (wr && paddr_i == OFS_SHIFT && in_phase && wcode[2:0] != 3'h0) begin // RL23
               next_sh_st = SH_RUN; // RL4
               next_sh_cnt = 32'h0;
               next_dim = '{valid: 1'b1, code: wcode}; // RL4
            end
         end
         SH_RUN: begin
            if (wr && paddr_i == OFS_SHIFT) begin
               next_dim = '{valid: 1'b1, code: wcode}; // RL4
               next_sh_cnt = 32'h0;
               if (wcode[2:0] == 3'h0) begin
                  next_sh_st = SH_SETTLE; // RL5
               end
            end else if (meas > lim_hi || meas < lim_lo) begin
               next_dim = '{valid: 1'b1, code: 4'h0}; // RL8
               next_sp = meas > lim_hi ? lim_hi : lim_lo; // RL8
               next_sh_st = SH_IDLE;
            end else if (sh_cnt >= 32'(TIMEOUT_CYCLES - 1)) begin
               next_dim = '{valid: 1'b1, code: 4'h0}; // RL7
               next_sh_cnt = 32'h0;
               next_sh_st = SH_SETTLE; // RL7
            end else begin
               next_sh_cnt = sh_cnt + 32'h1;
            end
         end
         SH_SETTLE: begin
            if (sh_cnt >= 32'(SETTLE_CYCLES - 1)) begin
               next_sp = meas; // RL6
               next_sh_st = SH_IDLE;
            end else begin
               next_sh_cnt = sh_cnt + 32'h1;
            end
         end
         default: next_sh_st = SH_IDLE;
      endcase
      // Temporary shift ends when the control phase ends with the shift idle
      if (phase_q && !in_phase && !ctrl[CTRL_PERM] && sh_st == SH_IDLE) begin
         next_sp = sp_saved; // RL9
      end
      if (sh_st == SH_IDLE && next_sh_st == SH_RUN) begin
         next_sp_saved = sp; // RL9
      end
      // Setpoint telegrams act in any phase; later ones win
      if (wr && paddr_i == OFS_PRESET) begin
         next_sp = pwdata_i[15:0]; // RL1
         next_sp_saved = pwdata_i[15:0]; // RL2
         next_ext_set = 1'b1; // RL3
      end
      if (wr && paddr_i == OFS_TEACH) begin
         if (tmode == TMODE_BOTH || pwdata_i[0] == (tmode == TMODE_ONE)) begin
            next_sp = meas; // RL10
            next_sp_saved = meas; // RL10
            next_ext_set = 1'b1; // RL3
         end else begin
            next_sp = cfg_sp; // RL11
            next_sp_saved = cfg_sp; // RL11
         end
      end
      if (wr && paddr_i == OFS_RESET) begin
         next_sp = cfg_sp; // RL12
         next_sp_saved = cfg_sp; // RL12
      end
      if (wr && paddr_i == OFS_DNLD) begin
         if (ctrl[CTRL_OVWR] || !ext_set) begin
            next_sp = cfg_sp; // RL13 RL14
            next_sp_saved = cfg_sp; // RL14
         end
      end
      // Upper band bound follows the setpoint
      prod = {8'h00, next_sp} * {16'h0000, ctrl[CTRL_HYST_LSB +: 8]};
      next_upper = next_sp + 16'(prod / 24'd100); // RL21
      // Channel derivation
      r2 = derive(ch1, offs2, hyst, on2);
      r3 = derive(ch1, offs3, hyst, on3);
      next_on2 = r2[8];
      next_on3 = r3[8];
      next_o2 = ctrl[1:0] >= 2'h2 ? r2[7:0] : 8'h00; // RL15
      next_o3 = ctrl[1:0] == 2'h3 ? r3[7:0] : 8'h00; // RL15
      // Read mux
      case (paddr_i)
         OFS_CTRL: next_rdata = {16'h0000, ctrl};
         OFS_CFG_SP: next_rdata = {16'h0000, cfg_sp};
         OFS_MEAS: next_rdata = {16'h0000, meas};
         OFS_LIMIT: next_rdata = {lim_hi, lim_lo};
         OFS_SETPT: next_rdata = {upper, sp};
         OFS_CH1: next_rdata = {24'h000000, ch1};
         OFS_OFFS: next_rdata = {7'h00, offs3, hyst[6:0], offs2};
         OFS_OUTS: next_rdata = {6'h00, sh_st, out_ch3_o, out_ch2_o, out_ch1_o};
         default: next_rdata = 32'h0;
      endcase
   end

   // Register stage; reset reloads the setpoint with CFG_SP_RST like the other registers
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= CTRL_RST;
         cfg_sp <= CFG_SP_RST;
         meas <= 16'h0000;
         lim_lo <= 16'h0000;
         lim_hi <= 16'hffff;
         ch1 <= 8'h00;
         offs2 <= 9'h000;
         offs3 <= 9'h000;
         hyst <= 8'h00;
         sp <= CFG_SP_RST;
         sp_saved <= CFG_SP_RST;
         upper <= CFG_SP_RST;
         ext_set <= 1'b0;
         sh_st <= SH_IDLE;
         sh_cnt <= 32'h0;
         phase_q <= 1'b0;
         on2 <= 1'b0;
         on3 <= 1'b0;
         dim_ch1_o <= '0;
         out_ch1_o <= 8'h00;
         out_ch2_o <= 8'h00;
         out_ch3_o <= 8'h00;
         abs_only_o <= 1'b0;
         prdata_o <= 32'h0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         cfg_sp <= next_cfg_sp;
         meas <= next_meas;
         lim_lo <= next_lim_lo;
         lim_hi <= next_lim_hi;
         ch1 <= next_ch1;
         offs2 <= next_offs2;
         offs3 <= next_offs3;
         hyst <= next_hyst;
         sp <= next_sp;
         sp_saved <= next_sp_saved;
         upper <= next_upper;
         ext_set <= next_ext_set;
         sh_st <= next_sh_st;
         sh_cnt <= next_sh_cnt;
         phase_q <= in_phase;
         on2 <= next_on2;
         on3 <= next_on3;
         dim_ch1_o <= next_dim;
         out_ch1_o <= ch1;
         out_ch2_o <= next_o2;
         out_ch3_o <= next_o3;
         abs_only_o <= ctrl[1:0] >= 2'h2; // RL16
         prdata_o <= rd ? next_rdata : 32'h0;
         pready_o <= 1'b1;
         pslverr_o <= 1'b0;
      end
   end

   // Checks
   property p_preset;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr && paddr_i == OFS_PRESET |=> ext_set;
   endproperty
   a_preset: assert property (p_preset) else $error("preset not recorded"); // RL14
   property p_preset_val;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr && paddr_i == OFS_PRESET |=> sp == $past(pwdata_i[15:0]);
   endproperty
   a_preset_val: assert property (p_preset_val) else $error("preset not taken"); // RL1
   property p_reset_sp;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr && paddr_i == OFS_RESET |=> sp == cfg_sp;
   endproperty
   a_reset_sp: assert property (p_reset_sp) else $error("reset not restored"); // RL12
   property p_shift_ignored;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      sh_st == SH_IDLE && wr && paddr_i == OFS_SHIFT && !in_phase |=> sh_st == SH_IDLE;
   endproperty
   a_shift_ignored: assert property (p_shift_ignored) else $error("shift out of phase"); // RL23
   property p_fwd;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      sh_st == SH_RUN && wr && paddr_i == OFS_SHIFT |=> dim_ch1_o.valid;
   endproperty
   a_fwd: assert property (p_fwd) else $error("dim not forwarded"); // RL4
   property p_stop_settle;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      sh_st == SH_RUN && wr && paddr_i == OFS_SHIFT && wcode[2:0] == 3'h0
      |=> sh_st == SH_SETTLE && dim_ch1_o.code[2:0] == 3'h0;
   endproperty
   a_stop_settle: assert property (p_stop_settle) else $error("stop not passed"); // RL5
   property p_settle_store;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      sh_st == SH_SETTLE && sh_cnt >= 32'(SETTLE_CYCLES - 1) |=> sp == $past(meas);
   endproperty
   a_settle_store: assert property (p_settle_store) else $error("settle not stored"); // RL6
   property p_ch_zero;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      ch1 == 8'h00 |=> out_ch2_o == 8'h00 && out_ch3_o == 8'h00;
   endproperty
   a_ch_zero: assert property (p_ch_zero) else $error("channels not off"); // RL19
   property p_upper;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $changed(sp) |-> upper >= sp;
   endproperty
   a_upper: assert property (p_upper) else $error("upper below setpoint"); // RL21
   property p_teach;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr && paddr_i == OFS_TEACH && tmode == TMODE_BOTH |=> sp == $past(meas);
   endproperty
   a_teach: assert property (p_teach) else $error("teach not taken"); // RL10
   c_shift: cover property (@(posedge clk_sys_i) sh_st == SH_RUN ##1 sh_st == SH_SETTLE);
   c_limit: cover property (@(posedge clk_sys_i) sh_st == SH_RUN ##1 sh_st == SH_IDLE);
   c_dnld: cover property (@(posedge clk_sys_i) wr && paddr_i == OFS_DNLD && ext_set);
   c_preset: cover property (@(posedge clk_sys_i) wr && paddr_i == OFS_PRESET);
endmodule // lsp_core

// ==== verification/lsp_dimmer.sv ====
`timescale 1ns/1ns
// Dimmer actuator on channel 1; it only listens, like a real bus subscriber
module lsp_dimmer (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Relative dimming telegram from channel 1
   input wire lsp_pkg::lsp_dim_s dim_i,
   // Observation for the bench
   output int n_tel_o,
   output int n_stop_o,
   output logic [3:0] last_code_o,
   output logic moving_o
);
   import lsp_pkg::*;

   // Count telegrams; a code with step bits zero halts the ramp
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         n_tel_o <= 0;
         n_stop_o <= 0;
         last_code_o <= 4'h0;
         moving_o <= 1'b0;
      end else if (dim_i.valid) begin
         last_code_o <= dim_i.code;
         if (dim_i.code[2:0] == 3'h0) begin
            n_stop_o <= n_stop_o + 1;
            moving_o <= 1'b0;
         end else begin
            n_tel_o <= n_tel_o + 1;
            moving_o <= 1'b1;
         end
      end
   end
endmodule // lsp_dimmer

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
// Bench for setpoint handling and channel derivation over APB
module testbench;
   import lsp_pkg::*;
   // Short counts keep the settle and timeout waits cheap
   localparam int SETTLE_T = 20;
   localparam int TOUT_T = 50;
   localparam int HYST_T = 20; // On-off hysteresis written to the offset register
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   lsp_dim_s dim_ch1;
   logic [7:0] out1, out2, out3;
   logic abs_only;
   int n_tel, n_stop;
   logic [3:0] last_code;
   logic moving;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [31:0] lfsr = 32'h0001017c; // Fixed seed
   logic [31:0] q;
   logic err;
   logic [15:0] cfg, v, m1, m2;
   logic act;
   int nt, ns;
   logic [1:0] tmodes [3] = '{TMODE_ONE, TMODE_ZERO, TMODE_BOTH};
   logic [7:0] rows [6] = '{8'h80, 8'h00, 8'h14, 8'h3c, 8'hfa, 8'h00};
   logic [7:0] e2, e3;
   logic on2e = 1'b0;
   logic on3e = 1'b0;

   always #25 clk_sys_i = ~clk_sys_i;

   lsp_core #(.SETTLE_CYCLES(SETTLE_T), .TIMEOUT_CYCLES(TOUT_T)) i_lsp_core (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .dim_ch1_o(dim_ch1), .out_ch1_o(out1),
      .out_ch2_o(out2), .out_ch3_o(out3), .abs_only_o(abs_only));

   lsp_dimmer i_lsp_dimmer (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .dim_i(dim_ch1), .n_tel_o(n_tel),
      .n_stop_o(n_stop), .last_code_o(last_code), .moving_o(moving));

   // Next random value, clipped to a plausible brightness range
   function automatic logic [15:0] rnd_val();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return 16'h0010 + {6'h00, lfsr[9:0]};
   endfunction

   // Control word; percentage hysteresis kept at 20
   function automatic logic [31:0] mk_ctrl(input logic [1:0] cnt, input logic perm,
         input logic [1:0] tm, input logic ovwr, input logic ph);
      return {16'h0000, 8'h14, 1'b0, ph, ovwr, tm, perm, cnt};
   endfunction

   // Upper band edge: setpoint plus 20 percent
   function automatic logic [15:0] upper(input logic [15:0] s);
      return s + 16'((32'(s) * 32'h14) / 32'h64);
   endfunction

   // Derived channel: off with channel 1, hysteresis on a negative offset, clamped to a byte
   function automatic logic [7:0] exp_ch(input logic [7:0] c, input int ofs, inout logic on);
      int s;
      s = int'(c) + ofs;
      if (c == 8'h00) on = 1'b0;
      else if (ofs >= 0 || s > HYST_T) on = 1'b1;
      else if (s <= 0) on = 1'b0;
      if (!on || s < 1) return 8'h00;
      if (s > 255) return 8'hff;
      return 8'(s);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // One APB transfer; answer is taken at the edge where pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk_sys_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      // Access edges: pready and read data are taken before this edge updates them
      @(posedge clk_sys_i);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge clk_sys_i);
         k++;
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         n_mismatch++;
         results();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      apb(1'b0, a, 32'h0, r);
   endtask

   // Poll the active setpoint; a wait that runs out ends the run
   task automatic wait_sp(input logic [15:0] e, input int bound);
      int k;
      logic [31:0] r;
      k = 0;
      rd(OFS_SETPT, r);
      while (r[15:0] !== e && k < bound) begin
         rd(OFS_SETPT, r);
         k++;
      end
      chk(32'(r[15:0]), 32'(e));
      if (r[15:0] !== e) results();
   endtask

   task automatic do_reset();
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
   endtask

   // Watchdog against a hung sequence
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      n_mismatch++;
      $display("ERROR %0t run did not finish", $time);
      results();
   end

   // Main sequence
   initial begin
      do_reset();
      cfg = CFG_SP_RST;
      rd(OFS_CFG_SP, q);
      chk(q, 32'(cfg));
      rd(OFS_CTRL, q);
      chk(q, 32'(CTRL_RST));
      rd(OFS_SETPT, q);
      chk(q, {upper(cfg), cfg});
      rd(8'h40, q);
      chk(q, 32'h0);
      chk(32'(err), 32'h0);
      chk(32'(abs_only), 32'h0);
      wr(OFS_LIMIT, 32'h03ff0010);
      // Random presets, with and without the control phase
      for (int i = 0; i < 4; i++) begin
         v = rnd_val();
         wr(OFS_CTRL, mk_ctrl(2'h1, 1'b0, TMODE_ONE, 1'b0, i[0]));
         wr(OFS_PRESET, 32'(v));
         rd(OFS_SETPT, q);
         chk(32'(q[15:0]), 32'(v));
      end
      wr(OFS_RESET, 32'h1);
      rd(OFS_SETPT, q);
      chk(32'(q[15:0]), 32'(cfg));
      // Every teach polarity: active value learns, opposite restores or learns
      for (int i = 0; i < 3; i++) begin
         act = (tmodes[i] == TMODE_ZERO) ? 1'b0 : 1'b1;
         wr(OFS_CTRL, mk_ctrl(2'h1, 1'b0, tmodes[i], 1'b0, 1'b0));
         m1 = rnd_val();
         wr(OFS_MEAS, 32'(m1));
         wr(OFS_TEACH, 32'(act));
         rd(OFS_SETPT, q);
         chk(32'(q[15:0]), 32'(m1));
         m2 = rnd_val();
         wr(OFS_MEAS, 32'(m2));
         wr(OFS_TEACH, 32'(~act));
         rd(OFS_SETPT, q);
         chk(32'(q[15:0]), 32'((tmodes[i] == TMODE_BOTH) ? m2 : cfg));
      end
      // Download with and without overwrite
      wr(OFS_CTRL, mk_ctrl(2'h1, 1'b0, TMODE_ONE, 1'b1, 1'b0));
      v = rnd_val();
      wr(OFS_PRESET, 32'(v));
      wr(OFS_DNLD, 32'h1);
      rd(OFS_SETPT, q);
      chk(32'(q[15:0]), 32'(cfg));
      wr(OFS_CTRL, mk_ctrl(2'h1, 1'b0, TMODE_ONE, 1'b0, 1'b0));
      wr(OFS_PRESET, 32'(v));
      wr(OFS_DNLD, 32'h1);
      rd(OFS_SETPT, q);
      chk(32'(q[15:0]), 32'(v));
      // Shift outside the control phase is dropped
      nt = n_tel;
      wr(OFS_SHIFT, 32'h9);
      repeat (3) @(posedge clk_sys_i);
      chk(32'(n_tel), 32'(nt));
      rd(OFS_SETPT, q);
      chk(32'(q[15:0]), 32'(v));
      // Temporary shift ended by a stop telegram
      wr(OFS_RESET, 32'h1);
      wr(OFS_CTRL, mk_ctrl(2'h1, 1'b0, TMODE_ONE, 1'b0, 1'b1));
      wr(OFS_MEAS, 32'h01f4);
      nt = n_tel;
      ns = n_stop;
      wr(OFS_SHIFT, 32'h9);
      repeat (2) @(posedge clk_sys_i);
      chk(32'(n_tel), 32'(nt + 1));
      chk(32'(last_code), 32'h9);
      wr(OFS_SHIFT, 32'h0);
      repeat (2) @(posedge clk_sys_i);
      chk(32'(n_stop), 32'(ns + 1));
      wait_sp(16'h01f4, 20);
      rd(OFS_SETPT, q);
      chk(32'(q[31:16]), 32'(upper(16'h01f4)));
      wr(OFS_CTRL, mk_ctrl(2'h1, 1'b0, TMODE_ONE, 1'b0, 1'b0));
      wait_sp(cfg, 5);
      // Permanent shift left running: the device stops it itself
      wr(OFS_CTRL, mk_ctrl(2'h1, 1'b1, TMODE_ONE, 1'b0, 1'b1));
      wr(OFS_MEAS, 32'h012c);
      ns = n_stop;
      wr(OFS_SHIFT, 32'h9);
      repeat (20) @(posedge clk_sys_i);
      chk(32'(n_stop), 32'(ns));
      wait_sp(16'h012c, 40);
      chk(32'(n_stop), 32'(ns + 1));
      wr(OFS_CTRL, mk_ctrl(2'h1, 1'b1, TMODE_ONE, 1'b0, 1'b0));
      rd(OFS_SETPT, q);
      chk(32'(q[15:0]), 32'h012c);
      // Limit crossed in mid-shift: the bound becomes the setpoint
      wr(OFS_CTRL, mk_ctrl(2'h1, 1'b1, TMODE_ONE, 1'b0, 1'b1));
      wr(OFS_LIMIT, 32'h03000100);
      wr(OFS_MEAS, 32'h0200);
      ns = n_stop;
      wr(OFS_SHIFT, 32'h9);
      wr(OFS_MEAS, 32'h0350);
      wait_sp(16'h0300, 20);
      chk(32'(n_stop), 32'(ns + 1));
      repeat (30) @(posedge clk_sys_i);
      rd(OFS_SETPT, q);
      chk(32'(q[15:0]), 32'h0300);
      // Three channels: offsets -50 and +10, hysteresis 20
      wr(OFS_CTRL, mk_ctrl(2'h3, 1'b1, TMODE_ONE, 1'b0, 1'b0));
      wr(OFS_OFFS, 32'h000a29ce);
      repeat (2) @(posedge clk_sys_i);
      chk(32'(abs_only), 32'h1);
      v = rnd_val();
      rows[5] = 8'h20 | v[7:0];
      // Row 3 lands inside the hysteresis band while channel 2 is off
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CH1, 32'(rows[i]));
         repeat (3) @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         chk(32'(out1), 32'(rows[i]));
         e2 = exp_ch(rows[i], -50, on2e);
         e3 = exp_ch(rows[i], 10, on3e);
         chk(32'(out2), 32'(e2));
         chk(32'(out3), 32'(e3));
      end
      // Two channels: channel 3 stays dark, outputs remain absolute
      wr(OFS_CTRL, mk_ctrl(2'h2, 1'b1, TMODE_ONE, 1'b0, 1'b0));
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(32'(out3), 32'h0);
      chk(32'(out2), 32'(e2));
      chk(32'(abs_only), 32'h1);
      // Fresh start: configured value rules until a preset or teach
      do_reset();
      wr(OFS_CFG_SP, 32'h01f4);
      wr(OFS_DNLD, 32'h1);
      rd(OFS_SETPT, q);
      chk(q, {upper(16'h01f4), 16'h01f4});
      results();
   end
endmodule // testbench
